// ==== logic/l3wa_way_alloc.sv ====
// last-level cache way allocation unit: class masks, thread tags, fill way selection
// assumes synchronous register-write strobes from the core and one fill request per cycle at most
`timescale 1ns/1ps
module l3wa_way_alloc #(
  parameter int VARIANT = l3wa_pkg::VARIANT_C4_W16,
  parameter bit MON_SUPPORT = 1'b0
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic maskWrEn,
  input wire logic [l3wa_pkg::TAG_W-1:0] maskWrIdx,
  input wire logic [l3wa_pkg::MAX_WAYS-1:0] maskWrData,
  output logic maskWrFault,
  input wire logic [l3wa_pkg::TAG_W-1:0] maskRdIdx,
  output logic [l3wa_pkg::MAX_WAYS-1:0] maskRdData,
  input wire logic assocWrEn,
  input wire logic [l3wa_pkg::THREAD_W-1:0] assocWrThread,
  input wire logic [l3wa_pkg::ASSOC_W-1:0] assocWrData,
  output logic assocWrFault,
  input wire logic [l3wa_pkg::THREAD_W-1:0] assocRdThread,
  output logic [l3wa_pkg::ASSOC_W-1:0] assocRdData,
  input wire l3wa_pkg::l3wa_fill_req_t fillReq,
  output logic fillDone,
  output logic [l3wa_pkg::MAX_WAYS-1:0] fillWayMask,
  output logic archAllocFeature,
  output logic monitorFeature
);

  localparam int NCLS = l3wa_pkg::classesOf(VARIANT);
  localparam int NWAY = l3wa_pkg::waysOf(VARIANT);
  localparam logic [l3wa_pkg::MAX_WAYS-1:0] LEGAL_WAYS = l3wa_pkg::MASK_RESET >> (l3wa_pkg::MAX_WAYS - NWAY);

  // single mask per class serves code and data fills alike
  logic [l3wa_pkg::MAX_WAYS-1:0] wayMask_q [l3wa_pkg::MAX_CLASSES];
  l3wa_pkg::l3wa_assoc_t assoc_q [l3wa_pkg::THREADS];
  logic maskWrFault_q;
  logic assocWrFault_q;
  logic fillDone_q;
  logic [l3wa_pkg::MAX_WAYS-1:0] fillWayMask_q;
  logic maskLegal;
  logic tagLegal;
  l3wa_pkg::l3wa_assoc_t assocWr;

  // mask must be non-empty, within the variant width and one contiguous run
  function automatic logic contiguous(input logic [l3wa_pkg::MAX_WAYS-1:0] m);
    logic [l3wa_pkg::MAX_WAYS-1:0] low;
    low = m & (~m + 16'h0001);
    return ((m + low) & m) == 16'h0000;
  endfunction

  always_comb
  begin
    maskLegal = (32'(maskWrIdx) < NCLS) && (maskWrData != 16'h0000)
      && ((maskWrData & ~LEGAL_WAYS) == 16'h0000) && contiguous(maskWrData);
    tagLegal = 32'(assocWrData[l3wa_pkg::ASSOC_TAG_LSB +: l3wa_pkg::TAG_W]) < NCLS
      && assocWrData[l3wa_pkg::ASSOC_W-1:l3wa_pkg::ASSOC_TAG_LSB + l3wa_pkg::TAG_W] == 28'h0000000;
    assocWr.serviceClassTag = assocWrData[l3wa_pkg::ASSOC_TAG_LSB +: l3wa_pkg::TAG_W];
    // without monitoring the field does not exist and reads zero
    assocWr.monitorTag = MON_SUPPORT ? assocWrData[l3wa_pkg::ASSOC_MON_LSB +: l3wa_pkg::MON_W]
      : l3wa_pkg::MON_RESET;
  end

  // only supported classes are ever written; the rest stay at reset
  genvar gc;
  generate
    for (gc = 0; gc < l3wa_pkg::MAX_CLASSES; gc++)
    begin : gMask
      always_ff @(posedge clk)
      begin
        if (rst)
          wayMask_q[gc] <= l3wa_pkg::MASK_RESET & LEGAL_WAYS;
        else if (maskWrEn && maskLegal && maskWrIdx == 4'(gc) && gc < NCLS)
          wayMask_q[gc] <= maskWrData;
      end
    end
  endgenerate

  genvar gt;
  generate
    for (gt = 0; gt < l3wa_pkg::THREADS; gt++)
    begin : gAssoc
      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          assoc_q[gt].serviceClassTag <= l3wa_pkg::TAG_RESET;
          assoc_q[gt].monitorTag <= l3wa_pkg::MON_RESET;
        end
        else if (assocWrEn && tagLegal && assocWrThread == 1'(gt))
          assoc_q[gt] <= assocWr;
      end
    end
  endgenerate

  // a refused write leaves state untouched and raises a one-cycle fault
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      maskWrFault_q <= 1'b0;
      assocWrFault_q <= 1'b0;
    end
    else
    begin
      maskWrFault_q <= maskWrEn && !maskLegal;
      assocWrFault_q <= assocWrEn && !tagLegal;
    end
  end

  // fill way selection, answered one cycle after the request
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      fillDone_q <= 1'b0;
      fillWayMask_q <= 16'h0000;
    end
    else
    begin
      fillDone_q <= fillReq.valid;
      if (fillReq.valid)
      begin
        if (fillReq.fromGpu)
          fillWayMask_q <= LEGAL_WAYS;
        else
          fillWayMask_q <= wayMask_q[assoc_q[fillReq.thread].serviceClassTag];
      end
    end
  end

  assign maskWrFault = maskWrFault_q;
  assign assocWrFault = assocWrFault_q;
  assign fillDone = fillDone_q;
  assign fillWayMask = fillWayMask_q;
  // reads are combinational views of stored state; unsupported classes read zero
  assign maskRdData = (32'(maskRdIdx) < NCLS) ? wayMask_q[maskRdIdx] : 16'h0000;
  assign assocRdData = {28'h0000000, assoc_q[assocRdThread].serviceClassTag, 22'h000000,
    assoc_q[assocRdThread].monitorTag};
  assign archAllocFeature = l3wa_pkg::ARCH_ALLOC_FLAG;
  assign monitorFeature = MON_SUPPORT;

  // assertions
  sequence sCoreFill;
    fillReq.valid && !fillReq.fromGpu;
  endsequence

  sequence sGpuFill;
    fillReq.valid && fillReq.fromGpu;
  endsequence

  a_core_fill_mask: assert property (@(posedge clk) disable iff (rst)
    sCoreFill |=> fillDone && fillWayMask == $past(wayMask_q[assoc_q[fillReq.thread].serviceClassTag]))
    else $error("core fill used wrong way mask");

  a_gpu_all_ways: assert property (@(posedge clk) disable iff (rst)
    sGpuFill |=> fillDone && fillWayMask == LEGAL_WAYS)
    else $error("graphics fill not given all ways");

  a_fill_within_width: assert property (@(posedge clk) disable iff (rst)
    fillDone |-> (fillWayMask & ~LEGAL_WAYS) == 16'h0000 && fillWayMask != 16'h0000)
    else $error("fill mask outside variant width");

  a_mask_write_store: assert property (@(posedge clk) disable iff (rst)
    maskWrEn && maskLegal ##1 !maskWrEn[*2] |-> maskRdIdx != $past(maskWrIdx, 2)
      || maskRdData == $past(maskWrData, 2))
    else $error("legal mask write not kept");

  a_mask_bad_fault: assert property (@(posedge clk) disable iff (rst)
    maskWrEn && 32'(maskWrIdx) >= NCLS |=> maskWrFault ##1 !maskWrFault || $past(maskWrEn && !maskLegal))
    else $error("unsupported class write not refused");

  a_assoc_tag_store: assert property (@(posedge clk) disable iff (rst)
    assocWrEn && tagLegal |=> assoc_q[$past(assocWrThread)].serviceClassTag
      == $past(assocWrData[l3wa_pkg::ASSOC_TAG_LSB +: l3wa_pkg::TAG_W]))
    else $error("class tag not stored");

  a_monitor_absent: assert property (@(posedge clk) disable iff (rst)
    !MON_SUPPORT |-> assocRdData[l3wa_pkg::MON_W-1:0] == l3wa_pkg::MON_RESET && !monitorFeature)
    else $error("monitor tag present without support");

  a_arch_flag_clear: assert property (@(posedge clk) disable iff (rst)
    !archAllocFeature)
    else $error("architectural allocation flag set");

endmodule

// ==== logic/l3wa_pkg.sv ====
// shared constants and carriers for the last-level cache way allocation unit
// assumes the core decodes its own register writes and hands them over as plain strobes
package l3wa_pkg;

  // variants: classes / way bitmask width
  localparam int VARIANT_C4_W16 = 0;
  localparam int VARIANT_C16_W12 = 1;
  localparam int VARIANT_C4_W12 = 2;
  localparam int CLASSES_C4 = 4;
  localparam int CLASSES_C16 = 16;
  localparam int WAYS_W16 = 16;
  localparam int WAYS_W12 = 12;

  // storage sized for the most classes and the widest way mask of any variant
  localparam int MAX_CLASSES = 16;
  localparam int MAX_WAYS = 16;
  localparam int TAG_W = 4;
  localparam int MON_W = 10;
  localparam int THREADS = 2;
  localparam int THREAD_W = 1;

  // association word layout: monitor tag low, class tag in upper half
  localparam int ASSOC_MON_LSB = 0;
  localparam int ASSOC_TAG_LSB = 32;
  localparam int ASSOC_W = 64;

  // reset values: every class may use every way, every thread in class 0
  localparam logic [MAX_WAYS-1:0] MASK_RESET = 16'hFFFF;
  localparam logic [TAG_W-1:0] TAG_RESET = 4'h0;
  localparam logic [MON_W-1:0] MON_RESET = 10'h000;

  // architectural allocation feature flag, always left clear
  localparam logic ARCH_ALLOC_FLAG = 1'b0;

  typedef struct packed {
    logic [TAG_W-1:0] serviceClassTag;
    logic [MON_W-1:0] monitorTag;
  } l3wa_assoc_t;

  typedef struct packed {
    logic valid;
    logic [THREAD_W-1:0] thread;
    logic fromGpu;
  } l3wa_fill_req_t;

  function automatic int classesOf(input int v);
    return (v == VARIANT_C16_W12) ? CLASSES_C16 : CLASSES_C4;
  endfunction

  function automatic int waysOf(input int v);
    return (v == VARIANT_C4_W16) ? WAYS_W16 : WAYS_W12;
  endfunction

endpackage

// ==== testbench/l3wa_way_alloc_tb.sv ====
// self-checking bench for the way allocation unit, 4-class 12-way variant
// assumes registered one-cycle answers and combinational read views; no monitoring support
`timescale 1ns/1ps
module l3wa_way_alloc_tb;
  localparam logic [15:0] ALL_WAYS = 16'h0FFF;
  logic clk, rst, maskWrEn, assocWrEn;
  logic [3:0] maskWrIdx, maskRdIdx;
  logic [15:0] maskWrData, maskRdData, fillWayMask;
  logic [0:0] assocWrThread, assocRdThread;
  logic [63:0] assocWrData, assocRdData;
  l3wa_pkg::l3wa_fill_req_t fillReq;
  logic maskWrFault, assocWrFault, fillDone, archAllocFeature, monitorFeature;
  int errTotal, checks, cycles;
  l3wa_way_alloc #(.VARIANT(l3wa_pkg::VARIANT_C4_W12), .MON_SUPPORT(1'b0)) dut (.clk(clk), .rst(rst),
    .maskWrEn(maskWrEn), .maskWrIdx(maskWrIdx), .maskWrData(maskWrData), .maskWrFault(maskWrFault),
    .maskRdIdx(maskRdIdx), .maskRdData(maskRdData), .assocWrEn(assocWrEn), .assocWrThread(assocWrThread),
    .assocWrData(assocWrData), .assocWrFault(assocWrFault), .assocRdThread(assocRdThread),
    .assocRdData(assocRdData), .fillReq(fillReq), .fillDone(fillDone), .fillWayMask(fillWayMask),
    .archAllocFeature(archAllocFeature), .monitorFeature(monitorFeature));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic final_report;
    $display("comparisons %0d, mismatches %0d", checks, errTotal);
    if (errTotal == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // hang guard, well above the roughly 40 cycles the run needs
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      errTotal++;
      final_report();
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      errTotal++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic rd_mask(input logic [3:0] idx, input logic [15:0] exp);
    maskRdIdx = idx;
    tick();
    chk({48'h0, maskRdData}, {48'h0, exp}, "mask read");
  endtask
  task automatic rd_assoc(input logic [0:0] th, input logic [63:0] exp);
    assocRdThread = th;
    tick();
    chk(assocRdData, exp, "association read");
  endtask
  // fault must pulse for exactly one cycle
  task automatic wr_mask(input logic [3:0] idx, input logic [15:0] data, input logic expFault);
    maskWrEn = 1'b1;
    maskWrIdx = idx;
    maskWrData = data;
    tick();
    maskWrEn = 1'b0;
    chk({63'h0, maskWrFault}, {63'h0, expFault}, "mask fault");
    tick();
    chk({63'h0, maskWrFault}, 64'h0, "mask fault end");
  endtask
  task automatic wr_assoc(input logic [0:0] th, input logic [63:0] data, input logic expFault);
    assocWrEn = 1'b1;
    assocWrThread = th;
    assocWrData = data;
    tick();
    assocWrEn = 1'b0;
    chk({63'h0, assocWrFault}, {63'h0, expFault}, "assoc fault");
    tick();
  endtask
  task automatic t_reset;
    for (int i = 0; i < 4; i++)
      rd_mask(i[3:0], ALL_WAYS);
    rd_mask(4'h4, 16'h0000);
    rd_mask(4'hF, 16'h0000);
    rd_assoc(1'b0, 64'h0);
    rd_assoc(1'b1, 64'h0);
    chk({63'h0, archAllocFeature}, 64'h0, "arch flag");
    chk({63'h0, monitorFeature}, 64'h0, "monitor flag");
  endtask
  task automatic t_masks;
    logic [3:0] idx [7] = '{4'h3, 4'h4, 4'h3, 4'h3, 4'h3, 4'h0, 4'h1};
    logic [15:0] val [7] = '{16'h00F0, 16'h000F, 16'h0000, 16'h1800, 16'h0101, 16'h0800, 16'h0FFF};
    logic bad [7] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
    for (int i = 0; i < 7; i++)
      wr_mask(idx[i], val[i], bad[i]);
    rd_mask(4'h1, 16'h0FFF);
    rd_mask(4'h3, 16'h00F0);
    rd_mask(4'h0, 16'h0800);
    rd_mask(4'h4, 16'h0000);
  endtask
  // monitor field is dropped without monitoring support
  // legal class tags stay below the smaller class count
  task automatic t_assoc;
    wr_assoc(1'b1, {28'h0, 4'h3, 22'h0, 10'h155}, 1'b0);
    rd_assoc(1'b1, {28'h0, 4'h3, 32'h0});
    wr_assoc(1'b0, {28'h0, 4'h4, 32'h0}, 1'b1);
    wr_assoc(1'b0, {24'h0, 4'h1, 4'h1, 32'h0}, 1'b1);
    rd_assoc(1'b0, 64'h0);
  endtask
  // back-to-back fills, class mask for core fills and all ways for the graphics fill
  task automatic t_fill;
    fillReq = '{valid: 1'b1, thread: 1'b0, fromGpu: 1'b0};
    tick();
    chk({48'h0, fillWayMask}, {48'h0, 16'h0800}, "fill thread 0");
    fillReq = '{valid: 1'b1, thread: 1'b1, fromGpu: 1'b0};
    tick();
    chk({48'h0, fillWayMask}, {48'h0, 16'h00F0}, "fill thread 1");
    fillReq = '{valid: 1'b1, thread: 1'b1, fromGpu: 1'b1};
    tick();
    chk({48'h0, fillWayMask}, {48'h0, ALL_WAYS}, "gpu fill");
    chk({63'h0, fillDone}, 64'h1, "fill done");
    fillReq = '{valid: 1'b0, thread: 1'b0, fromGpu: 1'b0};
    tick();
    chk({63'h0, fillDone}, 64'h0, "fill done end");
    chk({48'h0, fillWayMask}, {48'h0, ALL_WAYS}, "fill mask held");
  endtask
  initial
  begin
    rst = 1'b1;
    {maskWrEn, assocWrEn, maskWrIdx, maskRdIdx, maskWrData} = '0;
    {assocWrThread, assocRdThread, assocWrData} = '0;
    fillReq = '0;
    errTotal = 0;
    checks = 0;
    cycles = 0;
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    t_reset();
    t_masks();
    t_assoc();
    t_fill();
    final_report();
  end
endmodule
